// ---- rtl/i2csm_pkg.sv ----
package i2csm_pkg;

   // ****************************************
   // Register port geometry
   // ****************************************
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int AMASK_W = 10;
   localparam int IRQ_W = 5;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_AMASK    = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_SADDR    = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_TXBUF    = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_RXBUF    = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 5'h18;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int BIT_BEGIN = 3;
   localparam int BIT_DIR   = 2;
   localparam int BIT_RXF   = 1;
   localparam int BIT_TXF   = 0;

   localparam int IRQ_START  = 0;
   localparam int IRQ_STOP   = 1;
   localparam int IRQ_RXF    = 2;
   localparam int IRQ_TXDONE = 3;
   localparam int IRQ_MATCH  = 4;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic               start_seen;
      logic               stop_seen;
      logic               addr_done;
      logic               addr_rw;
      logic               rx_load;
      logic [BYTE_W-1:0]  rx_byte;
      logic               tx_done;
      logic               addr_check;
      logic [AMASK_W-1:0] addr_in;
   } i2csm_evt_t;

   typedef struct packed {
      logic               begin_flag;
      logic               dir_flag;
      logic               receive_full_flag;
      logic               transmit_full_flag;
      logic [AMASK_W-1:0] address_mask_bits;
      logic [AMASK_W-1:0] slave_addr;
      logic [BYTE_W-1:0]  receive_holding_buffer;
      logic [BYTE_W-1:0]  transmit_holding_buffer;
      logic [IRQ_W-1:0]   irq_stat;
      logic [IRQ_W-1:0]   irq_mask;
      logic [DATA_W-1:0]  rdata;
      logic               irq;
      logic               addr_match;
   } i2csm_state_t;

   // ****************************************
   // Reset values
   // ****************************************
   localparam i2csm_state_t STATE_RST = '0;
   localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

endpackage

// ---- rtl/i2csm_core.sv ----
`timescale 1ns/1ps

module i2csm_core
   import i2csm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic [DATA_W-1:0]      rdata,
   input  wire i2csm_evt_t        bus_evt,
   output logic [BYTE_W-1:0]      tx_byte,
   output logic                   tx_full,
   output logic                   addr_match,
   output logic                   irq
);

   // ****************************************
   // State
   // ****************************************
   i2csm_state_t st_reg;
   i2csm_state_t st_next;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // ****************************************
   // Address comparator
   // ****************************************
   logic [AMASK_W-1:0] bit_ok;
   logic               all_ok;

   generate
      for (genvar i = 0; i < AMASK_W; i++) begin : g_cmp
         // Masked positions always agree
         assign bit_ok[i] = st_reg.address_mask_bits[i] |
                            ~(bus_evt.addr_in[i] ^ st_reg.slave_addr[i]);
      end
   endgenerate

   assign all_ok = &bit_ok;

   // ****************************************
   // Decoded accesses
   // ****************************************
   logic wr_amask;
   logic wr_saddr;
   logic wr_txbuf;
   logic rd_rxbuf;
   logic wr_istat;
   logic wr_imask;
   logic [IRQ_W-1:0] irq_evt;

   assign wr_amask = wr & hit(addr, OFF_AMASK);
   assign wr_saddr = wr & hit(addr, OFF_SADDR);
   assign wr_txbuf = wr & hit(addr, OFF_TXBUF);
   assign rd_rxbuf = rd & hit(addr, OFF_RXBUF);
   assign wr_istat = wr & hit(addr, OFF_IRQ_STAT);
   assign wr_imask = wr & hit(addr, OFF_IRQ_MASK);

   always_comb begin
      irq_evt = '0;
      irq_evt[IRQ_START]  = bus_evt.start_seen;
      irq_evt[IRQ_STOP]   = bus_evt.stop_seen;
      irq_evt[IRQ_RXF]    = bus_evt.rx_load;
      irq_evt[IRQ_TXDONE] = bus_evt.tx_done;
      irq_evt[IRQ_MATCH]  = bus_evt.addr_check & all_ok;
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      st_next = st_reg;

      // Start beats stop in one cycle; the later condition is a start
      if (bus_evt.start_seen) begin
         st_next.begin_flag = 1'b1;
      end else if (bus_evt.stop_seen) begin
         st_next.begin_flag = 1'b0;
      end

      if (bus_evt.addr_done) begin
         st_next.dir_flag = bus_evt.addr_rw;
      end

      // Load wins over a read in the same cycle so no byte is lost
      if (bus_evt.rx_load) begin
         st_next.receive_full_flag      = 1'b1;
         st_next.receive_holding_buffer = bus_evt.rx_byte;
      end else if (rd_rxbuf) begin
         st_next.receive_full_flag = 1'b0;
      end

      // A fresh write wins over completion of the previous byte
      if (wr_txbuf) begin
         st_next.transmit_full_flag      = 1'b1;
         st_next.transmit_holding_buffer = wdata[BYTE_W-1:0];
      end else if (bus_evt.tx_done) begin
         st_next.transmit_full_flag = 1'b0;
      end

      if (wr_amask) begin
         st_next.address_mask_bits = wdata[AMASK_W-1:0];
      end
      if (wr_saddr) begin
         st_next.slave_addr = wdata[AMASK_W-1:0];
      end

      st_next.addr_match = bus_evt.addr_check & all_ok;

      // Set wins over write-one-to-clear
      if (wr_istat) begin
         st_next.irq_stat = st_reg.irq_stat & ~wdata[IRQ_W-1:0];
      end
      st_next.irq_stat = st_next.irq_stat | irq_evt;
      if (wr_imask) begin
         st_next.irq_mask = wdata[IRQ_W-1:0];
      end
      st_next.irq = |(st_next.irq_stat & st_next.irq_mask);

      // Read data reflect state before this cycle's updates
      st_next.rdata = READ_ZERO;
      if (rd) begin
         case (addr)
            OFF_STATUS: begin
               st_next.rdata[BIT_BEGIN] = st_reg.begin_flag;
               st_next.rdata[BIT_DIR]   = st_reg.dir_flag;
               st_next.rdata[BIT_RXF]   = st_reg.receive_full_flag;
               st_next.rdata[BIT_TXF]   = st_reg.transmit_full_flag;
            end
            OFF_AMASK: begin
               st_next.rdata[AMASK_W-1:0] = st_reg.address_mask_bits;
            end
            OFF_SADDR: begin
               st_next.rdata[AMASK_W-1:0] = st_reg.slave_addr;
            end
            OFF_TXBUF: begin
               st_next.rdata[BYTE_W-1:0] = st_reg.transmit_holding_buffer;
            end
            OFF_RXBUF: begin
               st_next.rdata[BYTE_W-1:0] = st_reg.receive_holding_buffer;
            end
            OFF_IRQ_STAT: begin
               st_next.rdata[IRQ_W-1:0] = st_reg.irq_stat;
            end
            OFF_IRQ_MASK: begin
               st_next.rdata[IRQ_W-1:0] = st_reg.irq_mask;
            end
            default: begin
               st_next.rdata = READ_ZERO;
            end
         endcase
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= STATE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rdata      = st_reg.rdata;
   assign tx_byte    = st_reg.transmit_holding_buffer;
   assign tx_full    = st_reg.transmit_full_flag;
   assign addr_match = st_reg.addr_match;
   assign irq        = st_reg.irq;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic [AMASK_W-1:0] miss_bits;
   assign miss_bits = (bus_evt.addr_in ^ st_reg.slave_addr) & ~st_reg.address_mask_bits;

   begin_set_a: assert property (
      bus_evt.start_seen |=> st_reg.begin_flag)
      else $error("begin flag not set after start");

   begin_clr_a: assert property (
      bus_evt.stop_seen && !bus_evt.start_seen |=> !st_reg.begin_flag)
      else $error("begin flag not cleared after stop");

   begin_hold_a: assert property (
      !bus_evt.start_seen && !bus_evt.stop_seen |=> $stable(st_reg.begin_flag))
      else $error("begin flag moved without a bus condition");

   dir_upd_a: assert property (
      bus_evt.addr_done |=> st_reg.dir_flag == $past(bus_evt.addr_rw))
      else $error("direction flag not taken from address byte");

   rx_fill_a: assert property (
      bus_evt.rx_load |=> st_reg.receive_full_flag
      ##0 st_reg.receive_holding_buffer == $past(bus_evt.rx_byte))
      else $error("receive byte not held or flag not set");

   rx_drain_a: assert property (
      rd && addr == OFF_RXBUF && !bus_evt.rx_load
      |=> !st_reg.receive_full_flag && rdata[BYTE_W-1:0] == $past(st_reg.receive_holding_buffer))
      else $error("receive read did not empty buffer");

   tx_fill_a: assert property (
      wr && addr == OFF_TXBUF |=> tx_full && tx_byte == $past(wdata[BYTE_W-1:0]))
      else $error("transmit write did not fill buffer");

   tx_done_a: assert property (
      bus_evt.tx_done && !(wr && addr == OFF_TXBUF) |=> !tx_full)
      else $error("transmit flag not cleared on completion");

   mask_hit_a: assert property (
      bus_evt.addr_check && miss_bits == '0 |=> addr_match)
      else $error("masked address failed to match");

   mask_miss_a: assert property (
      bus_evt.addr_check && miss_bits != '0 |=> !addr_match)
      else $error("unmasked difference still matched");

   mask_upper_a: assert property (
      rd && addr == OFF_AMASK |=> rdata[DATA_W-1:AMASK_W] == '0)
      else $error("upper mask bits read nonzero");

   status_ro_a: assert property (
      wr && addr == OFF_STATUS && !bus_evt.rx_load && !bus_evt.tx_done && !rd_rxbuf
      |=> $stable(st_reg.receive_full_flag) && $stable(st_reg.transmit_full_flag))
      else $error("status flags changed by software write");

   irq_level_a: assert property (
      (|(st_reg.irq_stat & st_reg.irq_mask)) == irq)
      else $error("interrupt line disagrees with status and mask");

   // ****************************************
   // Hold, register and interrupt checks
   // ****************************************
   dir_hold_a: assert property (
      !bus_evt.addr_done |=> $stable(st_reg.dir_flag))
      else $error("direction flag moved without an address byte");

   rx_hold_a: assert property (
      !bus_evt.rx_load && !(rd && addr == OFF_RXBUF) |=> $stable(st_reg.receive_full_flag))
      else $error("receive flag moved without an event");

   rxbuf_hold_a: assert property (
      !bus_evt.rx_load |=> $stable(st_reg.receive_holding_buffer))
      else $error("receive buffer changed without a load");

   tx_hold_a: assert property (
      !bus_evt.tx_done && !(wr && addr == OFF_TXBUF) |=> $stable(tx_full))
      else $error("transmit flag moved without an event");

   txbuf_hold_a: assert property (
      !(wr && addr == OFF_TXBUF) |=> $stable(tx_byte))
      else $error("transmit buffer changed without a write");

   status_upper_a: assert property (
      rd && addr == OFF_STATUS |=> rdata[DATA_W-1:BIT_BEGIN+1] == '0)
      else $error("unused status bits read nonzero");

   status_read_a: assert property (
      rd && addr == OFF_STATUS
      |=> rdata[BIT_BEGIN] == $past(st_reg.begin_flag) && rdata[BIT_DIR] == $past(st_reg.dir_flag)
      && rdata[BIT_RXF] == $past(st_reg.receive_full_flag) && rdata[BIT_TXF] == $past(tx_full))
      else $error("status read disagrees with flags");

   mask_write_a: assert property (
      wr && addr == OFF_AMASK |=> st_reg.address_mask_bits == $past(wdata[AMASK_W-1:0]))
      else $error("mask write not taken");

   mask_keep_a: assert property (
      !(wr && addr == OFF_AMASK) |=> $stable(st_reg.address_mask_bits))
      else $error("mask bits changed without a write");

   mask_read_a: assert property (
      rd && addr == OFF_AMASK |=> rdata[AMASK_W-1:0] == $past(st_reg.address_mask_bits))
      else $error("mask read disagrees with mask bits");

   match_pulse_a: assert property (
      !bus_evt.addr_check |=> !addr_match)
      else $error("address match without a compare");

   saddr_write_a: assert property (
      wr && addr == OFF_SADDR |=> st_reg.slave_addr == $past(wdata[AMASK_W-1:0]))
      else $error("slave address write not taken");

   rd_idle_a: assert property (
      !rd |=> rdata == '0)
      else $error("read data not zero outside a read");

   irq_start_a: assert property (
      bus_evt.start_seen |=> st_reg.irq_stat[IRQ_START])
      else $error("start event not latched");

   irq_stop_a: assert property (
      bus_evt.stop_seen |=> st_reg.irq_stat[IRQ_STOP])
      else $error("stop event not latched");

   irq_rx_a: assert property (
      bus_evt.rx_load |=> st_reg.irq_stat[IRQ_RXF])
      else $error("receive event not latched");

   irq_tx_a: assert property (
      bus_evt.tx_done |=> st_reg.irq_stat[IRQ_TXDONE])
      else $error("transmit event not latched");

   irq_match_a: assert property (
      bus_evt.addr_check && miss_bits == '0 |=> st_reg.irq_stat[IRQ_MATCH])
      else $error("match event not latched");

   irq_sticky_a: assert property (
      !(wr && addr == OFF_IRQ_STAT) |=> (st_reg.irq_stat & $past(st_reg.irq_stat)) == $past(st_reg.irq_stat))
      else $error("interrupt status bit dropped without a clear");

   irq_clear_a: assert property (
      wr && addr == OFF_IRQ_STAT && wdata[IRQ_START] && !bus_evt.start_seen |=> !st_reg.irq_stat[IRQ_START])
      else $error("interrupt status bit not cleared by write");

   irq_mask_a: assert property (
      wr && addr == OFF_IRQ_MASK |=> st_reg.irq_mask == $past(wdata[IRQ_W-1:0]))
      else $error("interrupt mask write not taken");

   reset_clear_a: assert property (
      disable iff (1'b0) rst
      |=> !st_reg.begin_flag && !st_reg.dir_flag && !st_reg.receive_full_flag && !tx_full
      && st_reg.address_mask_bits == '0 && !irq)
      else $error("state not cleared by reset");

endmodule

// ---- sim/i2csm_bus_model.sv ----
`timescale 1ns/1ps
// ******
// Stand-in for the bus engine side
// ******
module i2csm_bus_model
   import i2csm_pkg::*;
(
   input  wire logic clk,
   output i2csm_evt_t evt
);
   initial begin
      evt = '0;
   end
   // Idle edge between pulses, so each event is one clean cycle
   task automatic ev(input i2csm_evt_t e);
      @(posedge clk);
      evt <= e;
      @(posedge clk);
      evt <= '0;
   endtask
endmodule

// ---- sim/i2csm_core_tb.sv ----
`timescale 1ns/1ps
module i2csm_core_tb
   import i2csm_pkg::*;
;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   i2csm_evt_t        evt;
   logic [BYTE_W-1:0] tx_byte;
   logic              tx_full;
   logic              addr_match;
   logic              irq;
   int                fails = 0;
   int                total_checks = 0;
   int                cycles = 0;
   logic [9:0]        mk [6] = '{10'h000, 10'h000, 10'h001, 10'h3FF, 10'h200, 10'h1FF};
   logic [9:0]        ain [6] = '{10'h2A5, 10'h2A4, 10'h2A4, 10'h15A, 10'h0A5, 10'h0A5};
   logic [15:0]       hit [6] = '{16'h0001, 16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'h0000};

   always #10 clk = ~clk;

   i2csm_core i2csm_core_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .bus_evt(evt), .tx_byte(tx_byte), .tx_full(tx_full), .addr_match(addr_match), .irq(irq));
   i2csm_bus_model i2csm_bus_model_inst (.clk(clk), .evt(evt));

   // ******
   // Checking and closing
   // ******
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Limit sized well above the roughly 140 cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         give_verdict();
      end
   end

   // ******
   // Register port access
   // ******
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   task automatic irq_chk(input logic exp);
      @(posedge clk);
      #1;
      chk({15'h0000, irq}, {15'h0000, exp});
   endtask

   // ******
   // Tests
   // ******
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd_chk(OFF_STATUS, 16'h0000);
      rd_chk(OFF_AMASK, 16'h0000);
      chk({15'h0000, tx_full}, 16'h0000);
      rd_chk(5'h1C, 16'h0000);
      $display("test reset done");

      i2csm_bus_model_inst.ev(i2csm_evt_t'{start_seen: 1'b1, default: '0});
      rd_chk(OFF_STATUS, 16'h0008);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{start_seen: 1'b1, default: '0});
      rd_chk(OFF_STATUS, 16'h0008);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{stop_seen: 1'b1, default: '0});
      rd_chk(OFF_STATUS, 16'h0000);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{start_seen: 1'b1, stop_seen: 1'b1, default: '0});
      rd_chk(OFF_STATUS, 16'h0008);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{addr_done: 1'b1, addr_rw: 1'b1, default: '0});
      rd_chk(OFF_STATUS, 16'h000C);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{addr_done: 1'b1, default: '0});
      rd_chk(OFF_STATUS, 16'h0008);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{stop_seen: 1'b1, default: '0});
      $display("test begin and direction done");

      i2csm_bus_model_inst.ev(i2csm_evt_t'{rx_load: 1'b1, rx_byte: 8'h5A, default: '0});
      wr_reg(OFF_STATUS, 16'hFFFF);
      rd_chk(OFF_STATUS, 16'h0002);
      rd_chk(OFF_RXBUF, 16'h005A);
      rd_chk(OFF_STATUS, 16'h0000);
      wr_reg(OFF_STATUS, 16'hFFFF);
      rd_chk(OFF_STATUS, 16'h0000);
      wr_reg(OFF_TXBUF, 16'h00AB);
      #1;
      chk({8'h00, tx_byte}, 16'h00AB);
      chk({15'h0000, tx_full}, 16'h0001);
      rd_chk(OFF_STATUS, 16'h0001);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{tx_done: 1'b1, default: '0});
      #1;
      chk({15'h0000, tx_full}, 16'h0000);
      rd_chk(OFF_STATUS, 16'h0000);
      rd_chk(OFF_TXBUF, 16'h00AB);
      $display("test buffers done");

      wr_reg(OFF_AMASK, 16'hFFFF);
      rd_chk(OFF_AMASK, 16'h03FF);
      wr_reg(OFF_SADDR, 16'h02A5);
      rd_chk(OFF_SADDR, 16'h02A5);
      for (int i = 0; i < 6; i++) begin
         wr_reg(OFF_AMASK, {6'h00, mk[i]});
         i2csm_bus_model_inst.ev(i2csm_evt_t'{addr_check: 1'b1, addr_in: ain[i], default: '0});
         #1;
         chk({15'h0000, addr_match}, hit[i]);
         @(posedge clk);
         #1;
         chk({15'h0000, addr_match}, 16'h0000);
      end
      $display("test address mask done");

      wr_reg(OFF_IRQ_STAT, 16'h001F);
      wr_reg(OFF_IRQ_MASK, 16'h0001);
      irq_chk(1'b0);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{stop_seen: 1'b1, default: '0});
      irq_chk(1'b0);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{start_seen: 1'b1, default: '0});
      irq_chk(1'b1);
      rd_chk(OFF_IRQ_STAT, 16'h0003);
      wr_reg(OFF_IRQ_STAT, 16'h0001);
      irq_chk(1'b0);
      rd_chk(OFF_IRQ_STAT, 16'h0002);
      wr_reg(OFF_IRQ_MASK, 16'h001C);
      rd_chk(OFF_IRQ_MASK, 16'h001C);
      irq_chk(1'b0);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{tx_done: 1'b1, default: '0});
      irq_chk(1'b1);
      i2csm_bus_model_inst.ev(i2csm_evt_t'{rx_load: 1'b1, rx_byte: 8'h3C, default: '0});
      i2csm_bus_model_inst.ev(i2csm_evt_t'{addr_check: 1'b1, addr_in: 10'h2A5, default: '0});
      rd_chk(OFF_IRQ_STAT, 16'h001E);
      $display("test interrupt done");

      wr_reg(OFF_TXBUF, 16'h0055);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(OFF_STATUS, 16'h0000);
      rd_chk(OFF_AMASK, 16'h0000);
      rd_chk(OFF_IRQ_STAT, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      chk({8'h00, tx_byte}, 16'h0000);
      $display("test mid-run reset done");
      give_verdict();
   end
endmodule
